// *** design/pfr_top.sv ***
/*
 Closed-loop frequency regulator with a classic Wishbone register slave.
 Assumes analog samples arrive as 12-bit codes already synchronous to clk_i,
 and that frequencies are given in 0.01 Hz units.
*/
// How it works
// - Set point source: 0 off, 1 keypad, 2 voltage, 3 current, 4 stored.
// - Feedback codes 0/1 voltage input, 2/3 current input, even positive.
// - Negative feedback error is target minus feedback; positive the reverse.
// - Gain 0.0 to 10.0, default 1.0, scales error fraction of master frequency.
// - Integral time 0.00 to 100.0 s, default 1.00; zero stops integration.
// - Derivative time 0.00 to 1.00 s times the error change.
// - Gains may change while running and take effect at once.
// - First-order filter 0.0 to 2.5 s smooths derivative; zero bypasses.
// - Output limited to maximum frequency times 0 to 110 percent.
// - Feedback fault raised after abnormal longer than detection time; zero disables.
// - Fault response: 0 ramp stop, 1 coast stop, 2 keep running.
// - Feedback gain 0.0 to 10.0 scales the current input only.
// - Code 4 takes the stored set point, 0.00 to 600.0 Hz.
// - Offset above level for longer than its time raises offset output.
// - Sleep when output stays at or below sleep frequency past detection time.
// - Wake when command stays above wake frequency past detection time.
// - Regulator keeps computing while asleep.
// - Between minimum and lower bound: zero if sleep met, else lower bound.
// - Below minimum: zero if sleep met or disabled, lower bound while timing.
// - Minimum source code 0 takes a minimum frequency of zero.
// - Minimum source code 1 takes the configured minimum frequency.
`timescale 1ns/100ps
module pfr_top
   import pfr_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYC_DEF
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        run_i,
   input  wire logic [11:0] voltage_input_i,
   input  wire logic [11:0] current_input_i,
   input  wire logic [15:0] keypad_sp_i,
   input  wire logic [15:0] max_freq_i,
   input  wire logic [15:0] min_freq_i,
   input  wire logic [15:0] lower_freq_i,
   output logic      [15:0] freq_cmd_o,
   output logic      [15:0] pid_cmd_o,
   output logic             fault_warn_o,
   output logic             stop_ramp_o,
   output logic             stop_coast_o,
   output logic             pid_offset_o,
   output logic             asleep_o
);

////////////////////////////////////////////////////////////////////////////////
// Helpers

function automatic logic signed [31:0] sat(input logic signed [47:0] v,
                                           input logic signed [31:0] lo,
                                           input logic signed [31:0] hi);
   logic signed [47:0] l;
   logic signed [47:0] h;
   l = 48'(lo);
   h = 48'(hi);
   if (v < l) sat = lo;
   else if (v > h) sat = hi;
   else sat = v[31:0];
endfunction : sat

function automatic logic [15:0] lim(input logic [31:0] v, input logic [15:0] lo,
                                    input logic [15:0] hi);
   if (v < {16'h0000, lo}) lim = lo;
   else if (v > {16'h0000, hi}) lim = hi;
   else lim = v[15:0];
endfunction : lim

// Percent of a frequency, rounded down
function automatic logic [31:0] pct(input logic [15:0] f, input logic [15:0] p);
   pct = 32'((32'(f) * 32'(p)) / 32'd100);
endfunction : pct

function automatic logic [15:0] code2f(input logic [11:0] c, input logic [15:0] f);
   logic [27:0] m;
   m = 28'(c) * 28'(f);
   code2f = m[27:12];
endfunction : code2f

localparam logic signed [31:0] SMAX = 32'sh0001_FFFF;
localparam logic signed [31:0] SMIN = -32'sh0001_FFFF;
localparam logic signed [31:0] AMAX = 32'sh3FFF_FFFF;

////////////////////////////////////////////////////////////////////////////////
// Register slave

pfr_cfg_t   cfg_ff;
pfr_cfg_t   nxt_cfg;
logic [31:0] dat_ff;
logic        ack_ff;
logic [31:0] rdat;

wire         acc_req = wb_cyc_i & wb_stb_i & ~ack_ff;
wire         wr_req  = acc_req & wb_we_i & (&wb_sel_i[1:0]);
wire  [15:0] wd      = wb_dat_i[15:0];

always_comb begin
   nxt_cfg = cfg_ff;
   if (wr_req) begin
      case (wb_adr_i)
         OFS_CTRL: begin
            nxt_cfg.sp_sel  = (wd[CTRL_SP_LSB+:3] > SP_DIG) ? SP_OFF : wd[CTRL_SP_LSB+:3];
            nxt_cfg.fb_sel  = wd[CTRL_FB_LSB+:2];
            nxt_cfg.rsp     = wd[CTRL_RSP_LSB+:2];
            nxt_cfg.slp_en  = wd[CTRL_SLP_BIT];
            nxt_cfg.min_sel = wd[CTRL_MIN_BIT];
         end
         OFS_KP:   nxt_cfg.kp   = lim(32'(wd), ZERO16, KP_MAX);
         OFS_TI:   nxt_cfg.ti   = lim(32'(wd), ZERO16, TI_MAX);
         OFS_TD:   nxt_cfg.td   = lim(32'(wd), ZERO16, TD_MAX);
         OFS_ILIM: nxt_cfg.ilim = lim(32'(wd), ZERO16, ILIM_MAX);
         OFS_TF:   nxt_cfg.tf   = lim(32'(wd), ZERO16, TF_MAX);
         OFS_OLIM: nxt_cfg.olim = lim(32'(wd), ZERO16, OLIM_MAX);
         OFS_FDT:  nxt_cfg.fdt  = lim(32'(wd), ZERO16, FDT_MAX);
         OFS_FBG:  nxt_cfg.fbg  = lim(32'(wd), ZERO16, FBG_MAX);
         OFS_SPD:  nxt_cfg.spd  = lim(32'(wd), ZERO16, FRQ_MAX);
         OFS_OFL:  nxt_cfg.ofl  = lim(32'(wd), OFL_MIN, OFL_MAX);
         OFS_OFT:  nxt_cfg.oft  = lim(32'(wd), OFT_MIN, OFT_MAX);
         OFS_SLT:  nxt_cfg.slt  = lim(32'(wd), ZERO16, SLT_MAX);
         OFS_SLF:  nxt_cfg.slf  = lim(32'(wd), ZERO16, FRQ_MAX);
         OFS_WKF:  nxt_cfg.wkf  = lim(32'(wd), ZERO16, FRQ_MAX);
         default:  nxt_cfg = cfg_ff;
      endcase
   end
end

logic        fault_ff;
logic        ofs_ff;
pfr_state_t  st_ff;
logic [15:0] out_ff;
logic [15:0] cmd_ff;

always_comb begin
   case (wb_adr_i)
      OFS_CTRL: rdat = {22'h0, cfg_ff.min_sel, cfg_ff.slp_en, cfg_ff.rsp,
                        cfg_ff.fb_sel, 1'b0, cfg_ff.sp_sel};
      OFS_KP:   rdat = {16'h0000, cfg_ff.kp};
      OFS_TI:   rdat = {16'h0000, cfg_ff.ti};
      OFS_TD:   rdat = {16'h0000, cfg_ff.td};
      OFS_ILIM: rdat = {16'h0000, cfg_ff.ilim};
      OFS_TF:   rdat = {16'h0000, cfg_ff.tf};
      OFS_OLIM: rdat = {16'h0000, cfg_ff.olim};
      OFS_FDT:  rdat = {16'h0000, cfg_ff.fdt};
      OFS_FBG:  rdat = {16'h0000, cfg_ff.fbg};
      OFS_SPD:  rdat = {16'h0000, cfg_ff.spd};
      OFS_OFL:  rdat = {16'h0000, cfg_ff.ofl};
      OFS_OFT:  rdat = {16'h0000, cfg_ff.oft};
      OFS_SLT:  rdat = {16'h0000, cfg_ff.slt};
      OFS_SLF:  rdat = {16'h0000, cfg_ff.slf};
      OFS_WKF:  rdat = {16'h0000, cfg_ff.wkf};
      OFS_STAT: rdat = {29'h0, st_ff == ST_SLEEP, ofs_ff, fault_ff};
      OFS_FREQ: rdat = {cmd_ff, out_ff};
      default:  rdat = 32'h0000_0000;
   endcase
end

always_ff @(posedge clk_i) begin
   if (rst_i) begin
      cfg_ff <= '{sp_sel: SP_OFF, fb_sel: 2'h0, rsp: RSP_RAMP, slp_en: 1'b0,
                  min_sel: 1'b0, kp: KP_RST, ti: TI_RST, td: ZERO16,
                  ilim: ILIM_MAX, tf: ZERO16, olim: 16'h0064, fdt: FDT_RST,
                  fbg: FBG_RST, spd: ZERO16, ofl: OFL_RST, oft: OFT_RST,
                  slt: ZERO16, slf: ZERO16, wkf: ZERO16};
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
   end else begin
      cfg_ff <= nxt_cfg;
      ack_ff <= acc_req;
      dat_ff <= acc_req ? rdat : dat_ff;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Sample ticks

logic [31:0] tdiv_ff;
logic [6:0]  sdiv_ff;
wire         tick = (tdiv_ff == 32'(TICK_CYC - 1));
wire         slow = tick & (sdiv_ff == 7'(SLOW_DIV - 1));

always_ff @(posedge clk_i) begin
   if (rst_i) begin
      tdiv_ff <= 32'h0000_0000;
      sdiv_ff <= 7'h00;
   end else begin
      tdiv_ff <= tick ? 32'h0000_0000 : tdiv_ff + 32'h0000_0001;
      if (tick) sdiv_ff <= (sdiv_ff == 7'(SLOW_DIV - 1)) ? 7'h00 : sdiv_ff + 7'h01;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Set point, feedback, error

wire [15:0] fmax  = max_freq_i;
wire [15:0] vin_f = code2f(voltage_input_i, fmax);
wire [15:0] cin_f = code2f(current_input_i, fmax);
wire [15:0] cin_g = lim(32'(cin_f) * 32'(cfg_ff.fbg) / 32'd10, ZERO16, fmax);
logic [15:0] sp_f;

always_comb begin
   case (cfg_ff.sp_sel)
      SP_KEY:  sp_f = keypad_sp_i;
      SP_VIN:  sp_f = vin_f;
      SP_CIN:  sp_f = cin_f;
      SP_DIG:  sp_f = cfg_ff.spd;
      default: sp_f = ZERO16;
   endcase
end

wire [15:0] fb_f = cfg_ff.fb_sel[1] ? cin_g : vin_f;
wire signed [31:0] err = cfg_ff.fb_sel[0] ? 32'(sp_f) - 32'(fb_f)
                                          : 32'(fb_f) - 32'(sp_f);
wire               reg_on = (cfg_ff.sp_sel != SP_OFF) & run_i;

////////////////////////////////////////////////////////////////////////////////
// Regulator terms

logic signed [31:0] acc_ff;
logic signed [31:0] eprv_ff;
logic signed [31:0] dflt_ff;

// Proportional term in 0.01 Hz: gain tenths times error
// Gains are unsigned; cast them signed so a negative error keeps its sign
wire signed [31:0] p_t = sat(48'(err) * $signed(48'(cfg_ff.kp)) / 48'sd10,
                             SMIN, SMAX);

// Integral: sum of error over ticks divided by integral time in ticks
wire signed [31:0] ibnd = sat(48'(pct(fmax, cfg_ff.ilim)), 32'sd0, SMAX);
wire signed [31:0] iden = 32'(cfg_ff.ti) * 32'(TICK_PER_CS);
wire               i_on = (cfg_ff.ti != ZERO16);
wire signed [31:0] i_raw = i_on ? acc_ff / iden : 32'sd0;
wire signed [31:0] i_t = sat(48'(i_raw), -ibnd, ibnd);
// Anti-windup: stop summing once the clamp is reached in the error's direction
wire               i_hold = ((i_raw >= ibnd) & (err > 0)) | ((i_raw <= -ibnd) & (err < 0));
wire signed [31:0] nxt_acc = (!i_on || !reg_on) ? 32'sd0 :
                             i_hold ? acc_ff : sat(48'(acc_ff) + 48'(err), -AMAX, AMAX);

// Derivative: time in ticks times per-tick error change
wire signed [31:0] d_raw = sat(48'(err - eprv_ff) * $signed(48'(cfg_ff.td)) * 48'(TICK_PER_CS),
                               SMIN, SMAX);
wire signed [31:0] fden = 32'(cfg_ff.tf) * 32'(TICK_PER_DS);
wire signed [31:0] nxt_dflt = (cfg_ff.tf == ZERO16) ? d_raw
                            : dflt_ff + (d_raw - dflt_ff) / fden;
wire signed [31:0] d_t = (cfg_ff.tf == ZERO16) ? d_raw : dflt_ff;

// Output limit
wire signed [31:0] olim_f = sat(48'(pct(fmax, cfg_ff.olim)), 32'sd0, 32'sh0000_FFFF);
wire signed [31:0] u_sum  = sat(48'(p_t) + 48'(i_t) + 48'(d_t), 32'sd0, olim_f);
wire        [15:0] nxt_cmd = reg_on ? u_sum[15:0] : ZERO16;

// Terms update every tick, asleep or not, so the command stays live
always_ff @(posedge clk_i) begin
   if (rst_i) begin
      acc_ff  <= 32'sd0;
      eprv_ff <= 32'sd0;
      dflt_ff <= 32'sd0;
      cmd_ff  <= 16'h0000;
   end else if (tick) begin
      acc_ff  <= nxt_acc;
      eprv_ff <= err;
      dflt_ff <= reg_on ? nxt_dflt : 32'sd0;
      cmd_ff  <= nxt_cmd;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Supervision timers, counted in 0.1 s units

logic [15:0] fcnt_ff;
logic [15:0] ocnt_ff;
logic [15:0] scnt_ff;

wire        abn    = cfg_ff.fb_sel[1] & (current_input_i < LOSS_CODE);
wire [31:0] abserr = (err < 0) ? 32'(-err) : 32'(err);
wire        ofs_c  = reg_on & ((abserr * 32'd1000) > (32'(cfg_ff.ofl) * 32'(fmax)));
wire        slp_c  = (st_ff == ST_SLEEP) ? (cmd_ff > cfg_ff.wkf)
                                         : (out_ff <= cfg_ff.slf);
wire        f_met  = (cfg_ff.fdt != ZERO16) & (fcnt_ff > cfg_ff.fdt);
wire        o_met  = ocnt_ff > cfg_ff.oft;
wire        s_met  = cfg_ff.slp_en & (scnt_ff > cfg_ff.slt);

always_ff @(posedge clk_i) begin
   if (rst_i) begin
      fcnt_ff <= 16'h0000;
      ocnt_ff <= 16'h0000;
      scnt_ff <= 16'h0000;
   end else begin
      if (!abn) fcnt_ff <= 16'h0000;
      else if (slow && fcnt_ff != 16'hFFFF) fcnt_ff <= fcnt_ff + 16'h0001;
      if (!ofs_c) ocnt_ff <= 16'h0000;
      else if (slow && ocnt_ff != 16'hFFFF) ocnt_ff <= ocnt_ff + 16'h0001;
      if (!slp_c || s_met && st_ff != ST_OFF) scnt_ff <= 16'h0000;
      else if (slow && scnt_ff != 16'hFFFF) scnt_ff <= scnt_ff + 16'h0001;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Sleep state and output shaping

pfr_state_t nxt_st;

always_comb begin
   case (st_ff)
      ST_OFF:   nxt_st = reg_on ? ST_RUN : ST_OFF;
      ST_RUN:   nxt_st = !reg_on ? ST_OFF : (s_met ? ST_SLEEP : ST_RUN);
      ST_SLEEP: nxt_st = !reg_on ? ST_OFF : (s_met ? ST_RUN : ST_SLEEP);
      default:  nxt_st = ST_OFF;
   endcase
end

wire [15:0] fmin = cfg_ff.min_sel ? min_freq_i : ZERO16;
wire        stop = fault_ff & (cfg_ff.rsp != 2'h2);
logic [15:0] nxt_out;
logic        ramp_ff;
logic        coast_ff;
logic        asl_ff;

// On wake the output steps straight to the command, or to the lower bound or zero below it
always_comb begin
   if (st_ff != ST_RUN || stop) nxt_out = ZERO16;
   else if (cmd_ff < fmin)
      nxt_out = (cfg_ff.slp_en & !s_met & slp_c) ? lower_freq_i : ZERO16;
   else if (cmd_ff <= lower_freq_i)
      nxt_out = (cfg_ff.slp_en & s_met) ? ZERO16 : lower_freq_i;
   else nxt_out = cmd_ff;
end

always_ff @(posedge clk_i) begin
   if (rst_i) begin
      st_ff    <= ST_OFF;
      out_ff   <= 16'h0000;
      fault_ff <= 1'b0;
      ofs_ff   <= 1'b0;
      ramp_ff  <= 1'b0;
      coast_ff <= 1'b0;
      asl_ff   <= 1'b0;
   end else begin
      st_ff    <= nxt_st;
      out_ff   <= nxt_out;
      fault_ff <= f_met;
      ofs_ff   <= o_met;
      // Stop flags follow the same fault term, so they never lead the warning
      ramp_ff  <= f_met & (cfg_ff.rsp == RSP_RAMP);
      coast_ff <= f_met & (cfg_ff.rsp == RSP_COAST);
      asl_ff   <= (nxt_st == ST_SLEEP);
   end
end

assign wb_dat_o     = dat_ff;
assign wb_ack_o     = ack_ff;
assign freq_cmd_o   = out_ff;
assign pid_cmd_o    = cmd_ff;
assign fault_warn_o = fault_ff;
assign stop_ramp_o  = ramp_ff;
assign stop_coast_o = coast_ff;
assign pid_offset_o = ofs_ff;
assign asleep_o     = asl_ff;

endmodule : pfr_top

// *** design/pfr_pkg.sv ***
/*
 Package of the frequency regulator: register offsets, field positions,
 reset values, timing constants, the settings struct and the state type.
 Assumes a 100 MHz system clock and a 32-bit classic Wishbone bus.
*/
package pfr_pkg;
   // Timing
   localparam int CLK_NS       = 10;
   localparam int TICK_NS      = 1_000_000;         // Regulator sample period, 1 ms
   localparam int TICK_CYC_DEF = TICK_NS / CLK_NS;
   localparam int SLOW_DIV     = 100;               // Ticks per 0.1 s timer unit
   localparam int TICK_PER_CS  = 10;                // Ticks per 0.01 s
   localparam int TICK_PER_DS  = 100;               // Ticks per 0.1 s

   // Byte offsets
   localparam logic [7:0] OFS_CTRL  = 8'h00;
   localparam logic [7:0] OFS_KP    = 8'h04;
   localparam logic [7:0] OFS_TI    = 8'h08;
   localparam logic [7:0] OFS_TD    = 8'h0C;
   localparam logic [7:0] OFS_ILIM  = 8'h10;
   localparam logic [7:0] OFS_TF    = 8'h14;
   localparam logic [7:0] OFS_OLIM  = 8'h18;
   localparam logic [7:0] OFS_FDT   = 8'h1C;
   localparam logic [7:0] OFS_FBG   = 8'h20;
   localparam logic [7:0] OFS_SPD   = 8'h24;
   localparam logic [7:0] OFS_OFL   = 8'h28;
   localparam logic [7:0] OFS_OFT   = 8'h2C;
   localparam logic [7:0] OFS_SLT   = 8'h30;
   localparam logic [7:0] OFS_SLF   = 8'h34;
   localparam logic [7:0] OFS_WKF   = 8'h38;
   localparam logic [7:0] OFS_STAT  = 8'h3C;
   localparam logic [7:0] OFS_FREQ  = 8'h40;

   // Control register fields
   localparam int CTRL_SP_LSB  = 0;   // [2:0] set point source
   localparam int CTRL_FB_LSB  = 4;   // [5:4] feedback selector
   localparam int CTRL_RSP_LSB = 6;   // [7:6] fault response
   localparam int CTRL_SLP_BIT = 8;   // Sleep enable
   localparam int CTRL_MIN_BIT = 9;   // Minimum frequency source
   localparam int ST_FAULT_BIT = 0;
   localparam int ST_OFS_BIT   = 1;
   localparam int ST_SLP_BIT   = 2;

   // Ranges and reset values
   localparam logic [15:0] KP_MAX   = 16'h0064;  // 10.0
   localparam logic [15:0] KP_RST   = 16'h000A;  // 1.0
   localparam logic [15:0] TI_MAX   = 16'h2710;  // 100.00 s
   localparam logic [15:0] TI_RST   = 16'h0064;  // 1.00 s
   localparam logic [15:0] TD_MAX   = 16'h0064;  // 1.00 s
   localparam logic [15:0] ILIM_MAX = 16'h0064;  // 100 %
   localparam logic [15:0] TF_MAX   = 16'h0019;  // 2.5 s
   localparam logic [15:0] OLIM_MAX = 16'h006E;  // 110 %
   localparam logic [15:0] FDT_MAX  = 16'h8CA0;  // 3600.0 s
   localparam logic [15:0] FDT_RST  = 16'h0258;  // 60.0 s
   localparam logic [15:0] FBG_MAX  = 16'h0064;  // 10.0
   localparam logic [15:0] FBG_RST  = 16'h000A;  // 1.0
   localparam logic [15:0] FRQ_MAX  = 16'hEA60;  // 600.00 Hz
   localparam logic [15:0] OFL_MIN  = 16'h000A;  // 1.0 %
   localparam logic [15:0] OFL_MAX  = 16'h01F4;  // 50.0 %
   localparam logic [15:0] OFL_RST  = 16'h0064;  // 10.0 %
   localparam logic [15:0] OFT_MIN  = 16'h0001;  // 0.1 s
   localparam logic [15:0] OFT_MAX  = 16'h0BB8;  // 300.0 s
   localparam logic [15:0] OFT_RST  = 16'h0032;  // 5.0 s
   localparam logic [15:0] SLT_MAX  = 16'hFFDC;  // 6550.0 s
   localparam logic [15:0] ZERO16   = 16'h0000;
   localparam logic [11:0] LOSS_CODE = 12'h0333; // Current input below 4 mA

   // Set point and fault response codes
   localparam logic [2:0] SP_OFF = 3'h0;
   localparam logic [2:0] SP_KEY = 3'h1;
   localparam logic [2:0] SP_VIN = 3'h2;
   localparam logic [2:0] SP_CIN = 3'h3;
   localparam logic [2:0] SP_DIG = 3'h4;
   localparam logic [1:0] RSP_RAMP  = 2'h0;
   localparam logic [1:0] RSP_COAST = 2'h1;

   typedef struct packed {
      logic [2:0]  sp_sel;
      logic [1:0]  fb_sel;
      logic [1:0]  rsp;
      logic        slp_en;
      logic        min_sel;
      logic [15:0] kp, ti, td, ilim, tf, olim, fdt, fbg, spd, ofl, oft, slt, slf, wkf;
   } pfr_cfg_t;

   typedef enum logic [2:0] {
      ST_OFF   = 3'b001,
      ST_RUN   = 3'b010,
      ST_SLEEP = 3'b100
   } pfr_state_t;
endpackage : pfr_pkg

// *** testbench/pfr_props.sv ***
/*
 Checker of the regulator top ports: bus handshake, stop flags,
 output limit, update pace and shutdown. Assumes TICK_CYC of 10 to 55.
*/
`timescale 1ns/100ps
module pfr_props
   import pfr_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYC_DEF
) (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   input wire logic        run_i,
   input wire logic [15:0] max_freq_i,
   input wire logic [15:0] pid_cmd_o,
   input wire logic [15:0] freq_cmd_o,
   input wire logic        fault_warn_o,
   input wire logic        stop_ramp_o,
   input wire logic        stop_coast_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_latency: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   a_ack_unasked: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   a_read_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
      else $error("read data moved outside an answer");
   a_stop_excl: assert property (!(stop_ramp_o && stop_coast_o))
      else $error("ramp and coast stop together");
   a_stop_cause: assert property ((stop_ramp_o || stop_coast_o) |-> fault_warn_o)
      else $error("stop request without fault");
   // Widest limit is 110 percent; tighter settings are checked by the bench
   a_out_limit: assert property ({16'h0000, pid_cmd_o} * 32'h0000_0064 <= {16'h0000, max_freq_i} * 32'h0000_006E)
      else $error("command above output limit");
   a_tick_pace: assert property ($changed(pid_cmd_o) |=> $stable(pid_cmd_o) [*8])
      else $error("command changed between ticks");
   a_off_zero: assert property ($fell(run_i) |-> ##[1:60] (freq_cmd_o == 16'h0000 || run_i))
      else $error("output not zero after run drop");
endmodule : pfr_props

bind pfr_top pfr_props #(.TICK_CYC(TICK_CYC)) u_props (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .run_i(run_i), .max_freq_i(max_freq_i),
   .pid_cmd_o(pid_cmd_o), .freq_cmd_o(freq_cmd_o), .fault_warn_o(fault_warn_o),
   .stop_ramp_o(stop_ramp_o), .stop_coast_o(stop_coast_o));

// *** testbench/pfr_plant.sv ***
/*
 Model of the analog feedback inputs: converter codes follow the levels
 the bench sets, one clock late. Assumes the design samples on clk_i.
*/
`timescale 1ns/100ps
module pfr_plant (
   input  wire logic        clk_i,
   input  wire logic [11:0] vin_lvl_i,
   input  wire logic [11:0] cin_lvl_i,
   output logic      [11:0] voltage_input_o,
   output logic      [11:0] current_input_o
);
   // Codes land as a converter would, a clock after the level settles
   always_ff @(posedge clk_i) begin
      voltage_input_o <= vin_lvl_i;
      current_input_o <= cin_lvl_i;
   end
endmodule : pfr_plant

// *** testbench/pfr_top_tb.sv ***
/*
 Bench of the regulator: defaults, clamps, feedback sign, fault responses,
 sleep and wake. Assumes pfr_plant feeds the inputs and TICK_CYC of 10.
*/
`timescale 1ns/100ps
module pfr_top_tb
   import pfr_pkg::*;
;
   localparam int TCK = 10;
   logic        clk_i, rst_i, cyc, we, run, ack, fwarn, sramp, scoast, slp, ofs;
   logic [7:0]  adr;
   logic [31:0] wdat, rdat, q;
   logic [11:0] vin, cin, vpin, cpin;
   logic [15:0] fmax, freq, pid, kpd, fmn, flo;
   int          miscompares, checks_done;
   logic [7:0]  ra [8] = '{8'h04, 8'h08, 8'h1C, 8'h20, 8'h28, 8'h2C, 8'h0C, 8'h7C};
   logic [15:0] rv [8] = '{16'h000A, 16'h0064, 16'h0258, 16'h000A, 16'h0064, 16'h0032,
                           16'h0000, 16'h0000};
   logic [7:0]  ca [7] = '{8'h04, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24};
   logic [15:0] cv [7] = '{16'h0064, 16'h0064, 16'h0064, 16'h0019, 16'h006E, 16'h0064,
                           16'hEA60};
   always #5 clk_i = ~clk_i;
   pfr_plant u_plant (.clk_i(clk_i), .vin_lvl_i(vin), .cin_lvl_i(cin),
      .voltage_input_o(vpin), .current_input_o(cpin));
   pfr_top #(.TICK_CYC(TCK)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(q), .wb_ack_o(ack), .run_i(run), .voltage_input_i(vpin),
      .current_input_i(cpin), .keypad_sp_i(kpd), .max_freq_i(fmax),
      .min_freq_i(fmn), .lower_freq_i(flo), .freq_cmd_o(freq), .pid_cmd_o(pid),
      .fault_warn_o(fwarn), .stop_ramp_o(sramp), .stop_coast_o(scoast),
      .pid_offset_o(ofs), .asleep_o(slp));
   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Request held until ack is seen at a rising edge, then released
   task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1; we <= w; adr <= a; wdat <= {16'h0000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 40);
      rdat = q;
      cyc <= 1'b0; we <= 1'b0;
      if (n >= 40) begin
         miscompares++;
         stop_test();
      end
   endtask : wb
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      wb(1'b0, a, 16'h0000);
      chk(rdat, {16'h0000, e});
   endtask : rd
   task automatic ticks(input int n);
      repeat (n * TCK) @(posedge clk_i);
   endtask : ticks
   task automatic do_reset();
      @(posedge clk_i);
      rst_i <= 1'b1; run <= 1'b0; vin <= 12'h000; cin <= 12'h800;
      kpd <= 16'h0000;
      fmn <= 16'h0000;
      flo <= 16'h0000;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask : do_reset
   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
      for (int i = 0; i < 7; i++) begin
         wb(1'b1, ca[i], 16'hFFFF);
         rd(ca[i], cv[i]);
      end
      wb(1'b1, 8'h28, 16'h0000);
      rd(8'h28, 16'h000A);
      wb(1'b1, 8'h00, 16'h0005);
      rd(8'h00, 16'h0000);
   endtask : t_regs
   task automatic t_sign();
      do_reset();
      wb(1'b1, 8'h24, 16'h03E8); wb(1'b1, 8'h08, 16'h0000); wb(1'b1, 8'h00, 16'h0014);
      run <= 1'b1;
      ticks(5);
      chk(32'(pid), 32'h0000_03E8);
      wb(1'b1, 8'h00, 16'h0004);
      ticks(5);
      chk(32'(pid), 32'h0000_0000);
      chk(32'(freq), 32'h0000_0000);
      wb(1'b1, 8'h00, 16'h0014); wb(1'b1, 8'h18, 16'h0000);
      ticks(5);
      chk(32'(pid), 32'h0000_0000);
      kpd <= 16'h03E8;
      wb(1'b1, 8'h18, 16'h0064); wb(1'b1, 8'h00, 16'h0021);
      ticks(5);
      chk(32'(pid), 32'h0000_07D0);
      wb(1'b1, 8'h20, 16'h0005);
      ticks(5);
      chk(32'(pid), 32'h0000_01F4);
      flo <= 16'h07D0;
      ticks(2);
      chk(32'(freq), 32'h0000_07D0);
      fmn <= 16'h03E8;
      wb(1'b1, 8'h00, 16'h0221);
      ticks(2);
      chk(32'(freq), 32'h0000_0000);
      wb(1'b1, 8'h04, 16'h0000);
      ticks(5);
      chk(32'(pid), 32'h0000_0000);
   endtask : t_sign
   task automatic t_fault(input logic [1:0] code, input logic [15:0] fdt);
      do_reset();
      wb(1'b1, 8'h2C, 16'h0001);
      wb(1'b1, 8'h1C, fdt); wb(1'b1, 8'h24, 16'h03E8); wb(1'b1, 8'h00, {8'h00, code, 6'h34});
      run <= 1'b1; cin <= 12'h000;
      ticks(90);
      chk(32'(fwarn), 32'h0000_0000);
      chk(32'(ofs), 32'h0000_0000);
      ticks(260);
      chk(32'(fwarn), 32'(fdt != 16'h0000));
      chk(32'(ofs), 32'h0000_0001);
      chk(32'(sramp), 32'(fdt != 16'h0000 && code == 2'h0));
      chk(32'(scoast), 32'(fdt != 16'h0000 && code == 2'h1));
      cin <= 12'h800;
      ticks(2);
      chk(32'(fwarn), 32'h0000_0000);
   endtask : t_fault
   task automatic t_sleep();
      do_reset();
      wb(1'b1, 8'h30, 16'h0001); wb(1'b1, 8'h34, 16'h0064); wb(1'b1, 8'h38, 16'h00C8);
      wb(1'b1, 8'h00, 16'h0114);
      run <= 1'b1;
      ticks(350);
      chk(32'({slp, freq}), 32'h0001_0000);
      wb(1'b1, 8'h24, 16'h0BB8);
      ticks(50);
      chk(32'({slp, pid != 16'h0000}), 32'h0000_0003);
      ticks(300);
      chk(32'(slp), 32'h0000_0000);
      run <= 1'b0;
      ticks(1);
      chk(32'(freq), 32'h0000_0000);
   endtask : t_sleep
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0; rst_i = 1'b1; cyc = 1'b0; we = 1'b0; run = 1'b0;
      adr = 8'h00; wdat = 32'h0000_0000; vin = 12'h000; cin = 12'h800; fmax = 16'h1770;
      miscompares = 0; checks_done = 0;
      kpd = 16'h0000; fmn = 16'h0000; flo = 16'h0000;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_sign();
      for (int c = 0; c < 3; c++) t_fault(c[1:0], 16'h0001);
      t_fault(2'h0, 16'h0000);
      t_sleep();
      stop_test();
   end
endmodule : pfr_top_tb
